// *** hdl/nlc_defines.vh ***
// constants for the nested loop counter
`ifndef NLC_DEFINES_VH
`define NLC_DEFINES_VH

// state codes
`define NLC_ST_WAIT 1'b0
`define NLC_ST_COUNT 1'b1

// default width of a port-sourced loop control value
`define NLC_CTRL_WIDTH 8

// source selectors for start, increment and end
`define NLC_SRC_CONST 2'h0
`define NLC_SRC_OUTER 2'h1
`define NLC_SRC_MID 2'h2
`define NLC_SRC_PORT 2'h3

// reset values
`define NLC_RESET_COUNT 8'h00

`endif

// *** hdl/nlc_nested_loop_counter.v ***
// nested loop counter with up to three signed loops
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "nlc_defines.vh"

module nlc_nested_loop_counter #(
  parameter integer LEVELS = 3,
  parameter integer W = `NLC_CTRL_WIDTH,
  // per loop (0 outer, 1 middle, 2 inner): source selectors
  parameter [1:0] S0_SRC = `NLC_SRC_CONST,
  parameter [1:0] I0_SRC = `NLC_SRC_CONST,
  parameter [1:0] E0_SRC = `NLC_SRC_CONST,
  parameter [1:0] S1_SRC = `NLC_SRC_CONST,
  parameter [1:0] I1_SRC = `NLC_SRC_CONST,
  parameter [1:0] E1_SRC = `NLC_SRC_CONST,
  parameter [1:0] S2_SRC = `NLC_SRC_CONST,
  parameter [1:0] I2_SRC = `NLC_SRC_CONST,
  parameter [1:0] E2_SRC = `NLC_SRC_CONST,
  // build-time constants
  parameter signed [W-1:0] S0_CONST = 0,
  parameter signed [W-1:0] I0_CONST = 1,
  parameter signed [W-1:0] E0_CONST = 1,
  parameter signed [W-1:0] S1_CONST = 0,
  parameter signed [W-1:0] I1_CONST = 1,
  parameter signed [W-1:0] E1_CONST = 1,
  parameter signed [W-1:0] S2_CONST = 0,
  parameter signed [W-1:0] I2_CONST = 1,
  parameter signed [W-1:0] E2_CONST = 1
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // control
  input wire go,
  input wire enable,
  // port-sourced loop control values, signed
  input wire signed [W-1:0] start0_in,
  input wire signed [W-1:0] incr0_in,
  input wire signed [W-1:0] end0_in,
  input wire signed [W-1:0] start1_in,
  input wire signed [W-1:0] incr1_in,
  input wire signed [W-1:0] end1_in,
  input wire signed [W-1:0] start2_in,
  input wire signed [W-1:0] incr2_in,
  input wire signed [W-1:0] end2_in,
  // status
  output reg valid_out,
  output reg last_iteration_out,
  // counters, outer to inner
  output reg signed [W-1:0] count0,
  output reg signed [W-1:0] count1,
  output reg signed [W-1:0] count2
);

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // pick constant, enclosing counter or port
  function signed [W-1:0] pick;
    input [1:0] src;
    input signed [W-1:0] cval;
    input signed [W-1:0] outer;
    input signed [W-1:0] mid;
    input signed [W-1:0] pval;
    begin
      case (src)
        `NLC_SRC_CONST: pick = cval;
        `NLC_SRC_OUTER: pick = outer;
        `NLC_SRC_MID: pick = mid;
        default: pick = pval;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // step arithmetic and end test
  // ----------------------------------------------------------------
  // signed add, cut back to the counter width
  function signed [W-1:0] advance;
    input signed [W-1:0] cval;
    input signed [W-1:0] inc;
    reg signed [W:0] sum;
    begin
      sum = cval + inc;
      advance = sum[W-1:0];
    end
  endfunction

  // exact match of every active counter with its end
  function all_at_end;
    input signed [W-1:0] c0;
    input signed [W-1:0] c1;
    input signed [W-1:0] c2;
    reg hit0;
    reg hit1;
    reg hit2;
    begin
      hit0 = (c0 == pick(E0_SRC, E0_CONST, c0, c1, end0_in));
      hit1 = (LEVELS < 2) || (c1 == pick(E1_SRC, E1_CONST, c0, c1, end1_in));
      hit2 = (LEVELS < 3) || (c2 == pick(E2_SRC, E2_CONST, c0, c1, end2_in));
      all_at_end = hit0 && hit1 && hit2;
    end
  endfunction

  // ----------------------------------------------------------------
  // nesting depth
  // ----------------------------------------------------------------
  // one, two or three counters in use
  localparam HAS_MID = (LEVELS >= 2);
  localparam HAS_INNER = (LEVELS >= 3);

  // ----------------------------------------------------------------
  // state and next values
  // ----------------------------------------------------------------
  reg state;
  reg next_state;
  reg next_valid;
  reg next_last;
  reg signed [W-1:0] next_c0;
  reg signed [W-1:0] next_c1;
  reg signed [W-1:0] next_c2;

  // increments and inner end tests from the current counters
  reg signed [W-1:0] inc0;
  reg signed [W-1:0] inc1;
  reg signed [W-1:0] inc2;
  reg done1;
  reg done2;
  reg at_end;

  // counter values a go or a restart would load
  reg signed [W-1:0] load0;
  reg signed [W-1:0] load1;
  reg signed [W-1:0] load2;

  // counter values one step on
  reg signed [W-1:0] step0;
  reg signed [W-1:0] step1;
  reg signed [W-1:0] step2;
  reg step_last;

  // ----------------------------------------------------------------
  // control values
  // ----------------------------------------------------------------
  always @* begin
    // increments may follow an enclosing counter
    inc0 = pick(I0_SRC, I0_CONST, count0, count1, incr0_in);
    inc1 = pick(I1_SRC, I1_CONST, count0, count1, incr1_in);
    inc2 = pick(I2_SRC, I2_CONST, count0, count1, incr2_in);
    done1 = (LEVELS < 2) || (count1 == pick(E1_SRC, E1_CONST, count0, count1, end1_in));
    done2 = (LEVELS < 3) || (count2 == pick(E2_SRC, E2_CONST, count0, count1, end2_in));
    at_end = all_at_end(count0, count1, count2);
  end

  // ----------------------------------------------------------------
  // start values
  // ----------------------------------------------------------------
  always @* begin
    // outer start first, inner starts may use it
    load0 = pick(S0_SRC, S0_CONST, count0, count1, start0_in);
    load1 = pick(S1_SRC, S1_CONST, load0, count1, start1_in);
    load2 = pick(S2_SRC, S2_CONST, load0, load1, start2_in);
  end

  // ----------------------------------------------------------------
  // stepping
  // ----------------------------------------------------------------
  always @* begin
    step0 = count0;
    step1 = count1;
    step2 = count2;
    // innermost steps, a finished loop reloads its start
    if (LEVELS == 1) begin
      step0 = advance(count0, inc0);
    end else if (LEVELS == 2) begin
      if (!done1) begin
        step1 = advance(count1, inc1);
      end else begin
        step0 = advance(count0, inc0);
        step1 = pick(S1_SRC, S1_CONST, step0, count1, start1_in);
      end
    end else begin
      if (!done2) begin
        step2 = advance(count2, inc2);
      end else if (!done1) begin
        step1 = advance(count1, inc1);
        step2 = pick(S2_SRC, S2_CONST, count0, step1, start2_in);
      end else begin
        step0 = advance(count0, inc0);
        step1 = pick(S1_SRC, S1_CONST, step0, count1, start1_in);
        step2 = pick(S2_SRC, S2_CONST, step0, step1, start2_in);
      end
    end
    // last flag rises with the final counter values
    step_last = all_at_end(step0, step1, step2);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    next_valid = 1'b0;
    next_last = 1'b0;
    next_c0 = count0;
    next_c1 = count1;
    next_c2 = count2;
    if (!enable) begin
      // freeze state and counters, valid and last low, go ignored
      next_valid = 1'b0;
    end else if (go) begin
      // load starts, restart wins over stepping
      next_state = `NLC_ST_COUNT;
      next_c0 = load0;
      next_c1 = load1;
      next_c2 = load2;
      next_valid = 1'b1;
      // a single-iteration run is last at once
      next_last = all_at_end(load0, load1, load2);
    end else begin
      case (state)
        `NLC_ST_COUNT: begin
          if (last_iteration_out) begin
            // back to waiting after the last cycle
            next_state = `NLC_ST_WAIT;
          end else if (at_end) begin
            // resume after a freeze on the final values
            next_valid = 1'b1;
            next_last = 1'b1;
          end else begin
            next_valid = 1'b1;
            next_c0 = step0;
            next_c1 = step1;
            next_c2 = step2;
            next_last = step_last;
          end
        end
        default: begin
          next_state = `NLC_ST_WAIT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= `NLC_ST_WAIT;
      valid_out <= 1'b0;
      last_iteration_out <= 1'b0;
    end else begin
      state <= next_state;
      valid_out <= next_valid;
      last_iteration_out <= next_last;
    end
  end

  // ----------------------------------------------------------------
  // counter registers
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count0 <= {W{1'b0}};
    end else begin
      count0 <= next_c0;
    end
  end

  // unused levels read zero
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count1 <= {W{1'b0}};
    end else if (HAS_MID) begin
      count1 <= next_c1;
    end else begin
      count1 <= {W{1'b0}};
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count2 <= {W{1'b0}};
    end else if (HAS_INNER) begin
      count2 <= next_c2;
    end else begin
      count2 <= {W{1'b0}};
    end
  end

endmodule

// *** test/nlc_ctrl_source.sv ***
// surrounding logic that supplies loop control values
`timescale 1ns/1ps
module nlc_ctrl_source (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // request and counter state
  input wire [47:0] want,
  input wire valid_out,
  // values to the counter
  output reg [47:0] held
);
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 48'h0;
    end else if (!valid_out) begin
      held <= want;
    end
  end
endmodule

// *** test/nlc_props.sv ***
// assertions on the nested loop counter ports
`timescale 1ns/1ps
module nlc_props #(parameter integer W = 8) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // control
  input wire go,
  input wire enable,
  input wire signed [W-1:0] start0_in,
  input wire signed [W-1:0] end0_in,
  input wire signed [W-1:0] start2_in,
  input wire signed [W-1:0] incr2_in,
  input wire signed [W-1:0] end2_in,
  // status and counters
  input wire valid_out,
  input wire last_iteration_out,
  input wire signed [W-1:0] count0,
  input wire signed [W-1:0] count1,
  input wire signed [W-1:0] count2
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----
  // properties
  // ----
  en_low_idle_a:
    assert property (!enable |=> !valid_out && !last_iteration_out) else $error("en low out");
  en_low_hold_a:
    assert property (!enable |=> $stable(count0) && $stable(count2)) else $error("en low step");
  go_load_a:
    assert property (go && enable |=> valid_out && count0 == $past(start0_in)
      && count1 == 0 && count2 == $past(start2_in)) else $error("bad load");
  wait_idle_a:
    assert property (!valid_out && $past(enable) && !(go && enable) |=> !valid_out)
      else $error("self start");
  last_final_a:
    assert property (last_iteration_out |-> valid_out && count0 == end0_in
      && count1 == count0 && count2 == end2_in) else $error("bad last");
  last_single_a:
    assert property (last_iteration_out |=> !last_iteration_out) else $error("long last");
  last_return_a:
    assert property (last_iteration_out && enable && !go |=> !valid_out) else $error("no return");
  inner_step_a:
    assert property (valid_out && enable && !go && count2 != end2_in
      |=> count2 - $past(count2) == $past(incr2_in)) else $error("bad step");
  cover property (last_iteration_out);
  cover property (valid_out && go && enable);
  cover property (valid_out && !enable);
endmodule

bind nlc_nested_loop_counter nlc_props #(.W(W)) i_props (.mclk(mclk), .rst_n(rst_n),
  .go(go), .enable(enable), .start0_in(start0_in), .end0_in(end0_in),
  .start2_in(start2_in), .incr2_in(incr2_in), .end2_in(end2_in), .valid_out(valid_out),
  .last_iteration_out(last_iteration_out), .count0(count0), .count1(count1), .count2(count2));

// *** test/testbench.sv ***
// self-checking bench for the nested loop counter
`timescale 1ns/1ps
`include "nlc_defines.vh"
module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic enable = 1'b1;
  logic [47:0] want = 48'h0;
  logic [7:0] snap;
  wire [47:0] held;
  wire valid_out;
  wire last_iteration_out;
  wire signed [7:0] count0;
  wire signed [7:0] count1;
  wire signed [7:0] count2;
  integer fails = 0;
  integer checked = 0;
  integer n;
  integer k;
  // controls s0 i0 e0 s2 i2 e2, then valid cycles and final counts
  logic [79:0] rows [3] = '{80'h00010100010003010100, 80'h02ff0105fe010f010101,
    80'h000100fd01ff030000ff};
  always #2.5 mclk = ~mclk;
  nlc_ctrl_source i_src (.mclk(mclk), .rst_n(rst_n), .want(want), .valid_out(valid_out),
    .held(held));
  nlc_nested_loop_counter #(.S0_SRC(`NLC_SRC_PORT), .I0_SRC(`NLC_SRC_PORT),
    .E0_SRC(`NLC_SRC_PORT), .E1_SRC(`NLC_SRC_OUTER), .S2_SRC(`NLC_SRC_PORT),
    .I2_SRC(`NLC_SRC_PORT), .E2_SRC(`NLC_SRC_PORT)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .go(go), .enable(enable), .start0_in(held[47:40]), .incr0_in(held[39:32]),
    .end0_in(held[31:24]), .start1_in(8'h00), .incr1_in(8'h01), .end1_in(8'h00),
    .start2_in(held[23:16]), .incr2_in(held[15:8]), .end2_in(held[7:0]),
    .valid_out(valid_out), .last_iteration_out(last_iteration_out),
    .count0(count0), .count1(count1), .count2(count2));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails = fails + 1;
    end
  endtask
  task automatic complete_run;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic pulse_go;
    @(negedge mclk) go = 1'b1;
    @(negedge mclk) go = 1'b0;
  endtask
  task automatic load(input integer r);
    @(negedge mclk) want = rows[r][79:32];
    repeat (2) @(negedge mclk);
  endtask
  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    for (int r = 0; r < 3; r++) begin
      load(r);
      pulse_go();
      n = 0;
      for (k = 0; k < 200 && last_iteration_out !== 1'b1; k++) begin
        if (valid_out === 1'b1) n = n + 1;
        @(negedge mclk);
      end
      if (k == 200) begin
        fails = fails + 1;
        complete_run();
      end
      chk(8'(n + 1), rows[r][31:24]);
      chk(count0, rows[r][23:16]);
      chk(count1, rows[r][15:8]);
      chk(count2, rows[r][7:0]);
      @(negedge mclk);
      chk({7'h0, valid_out}, 8'h00);
    end
    load(1);
    pulse_go();
    repeat (3) @(negedge mclk);
    pulse_go();
    chk(count0, 8'h02);
    chk(count2, 8'h05);
    @(negedge mclk);
    enable = 1'b0;
    go = 1'b1;
    snap = count2;
    @(negedge mclk);
    go = 1'b0;
    chk({7'h0, valid_out}, 8'h00);
    chk(count2, snap);
    enable = 1'b1;
    @(negedge mclk);
    chk(count2, 8'h01);
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk({7'h0, valid_out}, 8'h00);
    complete_run();
  end
endmodule
